/* testbench/dac_dual_latch_bus_loader_test.sv */
`timescale 1ns/1ps
`include "dacldr_defines.vh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, a); end end
module dac_dual_latch_bus_loader_test;
  logic        CORE_CLK, SRST, START, LEFT_JUSTIFY, DOUBLE_BUF;
  logic        REDUCED_PART, EXT_XFER_REQ, BUSY, DONE, CHIP_SELECT_N;
  logic        WRITE_STROBE_FIRST_N, WRITE_STROBE_SECOND_N, BYTE_SELECT;
  logic        XFER_N, JUSTIFY_SELECT, ADDR_BIT_ZERO;
  logic [15:0] SRC_WORD, DATA_BUS;
  logic [1:0]  BUS_MODE, XFER_MODE, m, b;
  logic [9:0]  dac_out, last_val, ev;
  logic [9:0]  exp_q[$];
  integer      err_count, cmp_count, seed, cyc, j;

  initial
  begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  dacldr_host dacldr_host_inst
  (
    .CORE_CLK, .SRST, .START, .SRC_WORD, .BUS_MODE, .XFER_MODE,
    .LEFT_JUSTIFY, .DOUBLE_BUF, .REDUCED_PART, .EXT_XFER_REQ, .BUSY, .DONE,
    .DATA_BUS, .CHIP_SELECT_N, .WRITE_STROBE_FIRST_N,
    .WRITE_STROBE_SECOND_N, .BYTE_SELECT, .XFER_N, .JUSTIFY_SELECT,
    .ADDR_BIT_ZERO
  );

  dacldr_device dacldr_device_inst
  (
    .data(DATA_BUS), .wide(BUS_MODE != `DACLDR_BUS_8),
    .cs_n(CHIP_SELECT_N), .wr1_n(WRITE_STROBE_FIRST_N),
    // The bench is the outside logic that owns the transfer strobe in
    // external mode, standing in for a second select decode.
    .wr2_n(WRITE_STROBE_SECOND_N & ~EXT_XFER_REQ), .bsel(BYTE_SELECT),
    .xfer_n(XFER_N & ~EXT_XFER_REQ),
    .lj(JUSTIFY_SELECT), .reduced(REDUCED_PART), .dac_val(dac_out)
  );

  always @(negedge CORE_CLK)
    if (DONE === 1'b1)
    begin
      ev = exp_q.size() ? exp_q.pop_front() : ~dac_out;
      `CHK("dac", ev, dac_out)
    end

  always @(posedge CORE_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      finish_test();
    end
  end

  task finish_test;
    begin
      $display("Checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // The next word always differs from the last, so a lost transfer shows.
  task run(input logic [1:0] bm, xm, input logic lj, rp, db);
    logic [15:0] w;
    logic [9:0]  e;
    integer      n;
    begin
      w = 16'($random(seed));
      if (((lj | rp) ? w[15:6] : w[9:0]) === last_val) w = ~w;
      e = (lj | rp) ? w[15:6] : w[9:0];
      @(posedge CORE_CLK);
      #1;
      BUS_MODE = bm; XFER_MODE = xm; LEFT_JUSTIFY = lj;
      REDUCED_PART = rp; DOUBLE_BUF = db; SRC_WORD = w;
      @(posedge CORE_CLK);
      #1;
      START = 1'b1;
      exp_q.push_back(e);
      @(posedge CORE_CLK);
      #1;
      if (xm == `DACLDR_MODE_FLOW)
      begin
        repeat (15) @(posedge CORE_CLK);
        #1;
        `CHK("flow", e, dac_out)
      end
      START = 1'b0;
      if (xm == `DACLDR_MODE_EXT)
      begin
        repeat (40) @(posedge CORE_CLK);
        #1;
        `CHK("held", last_val, dac_out)
        EXT_XFER_REQ = 1'b1;
      end
      n = 0;
      while (BUSY !== 1'b0 && n < 500)
      begin
        @(posedge CORE_CLK);
        #1;
        n++;
      end
      `CHK("busy", 1'b0, BUSY)
      EXT_XFER_REQ = 1'b0;
      last_val = e;
    end
  endtask

  initial
  begin
    seed = 18; err_count = 0; cmp_count = 0; cyc = 0; last_val = 10'h000;
    SRST = 1'b1; START = 1'b0; SRC_WORD = 16'h0000; BUS_MODE = 2'h0;
    XFER_MODE = 2'h0; LEFT_JUSTIFY = 1'b0; DOUBLE_BUF = 1'b0;
    REDUCED_PART = 1'b0; EXT_XFER_REQ = 1'b0;
    repeat (6) @(posedge CORE_CLK);
    #1;
    SRST = 1'b0;
    for (m = 2'h0; m < 2'h3; m++)
      for (j = 0; j < 3; j++)
        run(`DACLDR_BUS_8, m, j == 1, j == 2, 1'b0);
    for (b = 2'h1; b < 2'h3; b++)
      for (m = 2'h0; m < 2'h3; m++)
        run(b, (m == 2'h2) ? `DACLDR_MODE_FLOW : `DACLDR_MODE_AUTO,
            m[0], 1'b0, m == 2'h1);
    finish_test();
  end
endmodule

/* testbench/dacldr_checker.sv */
`timescale 1ns/1ps
`include "dacldr_defines.vh"
// ----------------------------------------
// Port checker for the host controller.
// ----------------------------------------
module dacldr_checker
(
  input logic        CORE_CLK,
  input logic        SRST,
  input logic        START,
  input logic [1:0]  BUS_MODE,
  input logic [1:0]  XFER_MODE,
  input logic        LEFT_JUSTIFY,
  input logic        REDUCED_PART,
  input logic        BUSY,
  input logic        DONE,
  input logic [15:0] DATA_BUS,
  input logic        CHIP_SELECT_N,
  input logic        WRITE_STROBE_FIRST_N,
  input logic        WRITE_STROBE_SECOND_N,
  input logic        BYTE_SELECT,
  input logic        XFER_N,
  input logic        JUSTIFY_SELECT,
  input logic        ADDR_BIT_ZERO
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  a_reset_idle: assert property (disable iff (1'b0)
    SRST |=> CHIP_SELECT_N && WRITE_STROBE_FIRST_N && XFER_N && !BUSY)
    else $error("bus not idle after reset");
  a_wr_in_cs: assert property (!WRITE_STROBE_FIRST_N |->
    !CHIP_SELECT_N) else $error("write strobe without select");
  a_wr_pulse_len: assert property ($fell(WRITE_STROBE_FIRST_N) |->
    !WRITE_STROBE_FIRST_N [*5]) else $error("write pulse short");
  a_bus_held: assert property (!CHIP_SELECT_N && $past(!CHIP_SELECT_N)
    |-> $stable(DATA_BUS) && $stable(BYTE_SELECT))
    else $error("bus moved during write");
  a_addr_mirror: assert property (ADDR_BIT_ZERO == BYTE_SELECT)
    else $error("address bit differs from byte select");
  a_justify_pin: assert property (!$past(SRST) |-> JUSTIFY_SELECT ==
    $past(LEFT_JUSTIFY | REDUCED_PART)) else $error("justify pin wrong");
  a_auto_xfer: assert property (BUS_MODE == `DACLDR_BUS_8 &&
    XFER_MODE == `DACLDR_MODE_AUTO && !WRITE_STROBE_FIRST_N && !BYTE_SELECT
    |-> !WRITE_STROBE_SECOND_N && !XFER_N) else $error("auto transfer lost");
  a_proc_third: assert property (BUS_MODE == `DACLDR_BUS_8 &&
    XFER_MODE == `DACLDR_MODE_PROC && !XFER_N |->
    !WRITE_STROBE_FIRST_N && !WRITE_STROBE_SECOND_N)
    else $error("transfer without both strobes");
  a_right_pair: assert property (BUS_MODE == `DACLDR_BUS_8 &&
    !CHIP_SELECT_N && !BYTE_SELECT && !JUSTIFY_SELECT
    |-> DATA_BUS[7:2] == 6'h00)
    else $error("right second byte wrong");
  a_left_pair: assert property (BUS_MODE == `DACLDR_BUS_8 &&
    !CHIP_SELECT_N && !BYTE_SELECT && JUSTIFY_SELECT
    |-> DATA_BUS[5:0] == 6'h00)
    else $error("left second byte wrong");
  a_load_bounded: assert property ($rose(BUSY) |-> ##[1:400] DONE)
    else $error("load never finished");
  a_start_taken: assert property (START && !BUSY |=> BUSY)
    else $error("start ignored in idle");

  c_auto: cover property (DONE && XFER_MODE == `DACLDR_MODE_AUTO);
  c_proc: cover property (DONE && XFER_MODE == `DACLDR_MODE_PROC);
  c_ext: cover property (DONE && XFER_MODE == `DACLDR_MODE_EXT);
  c_flow: cover property (DONE && XFER_MODE == `DACLDR_MODE_FLOW);
endmodule

bind dacldr_host dacldr_checker dacldr_checker_inst
(
  .CORE_CLK, .SRST, .START, .BUS_MODE, .XFER_MODE, .LEFT_JUSTIFY,
  .REDUCED_PART, .BUSY, .DONE, .DATA_BUS, .CHIP_SELECT_N,
  .WRITE_STROBE_FIRST_N, .WRITE_STROBE_SECOND_N, .BYTE_SELECT, .XFER_N,
  .JUSTIFY_SELECT, .ADDR_BIT_ZERO
);

/* testbench/dacldr_device.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Behavioural model of the two-stage converter.
// ----------------------------------------
module dacldr_device
(
  input  logic [15:0] data,
  input  logic        wide,
  input  logic        cs_n,
  input  logic        wr1_n,
  input  logic        wr2_n,
  input  logic        bsel,
  input  logic        xfer_n,
  input  logic        lj,
  input  logic        reduced,
  output logic [9:0]  dac_val
);
  logic       left;
  logic [9:0] pins;
  logic [9:0] in_r;

  // The reduced part has no justify pin, so it is always left justified.
  assign left = lj | reduced;
  // Two lines are shared on a byte bus, so the first write also loads them.
  assign pins = wide ? (left ? data[15:6] : data[9:0])
              : (left ? {data[7:0], data[7:6]} : {data[1:0], data[7:0]});

  always_latch
    if (!cs_n && !wr1_n)
      if (bsel) in_r <= pins;
      else if (left) in_r[1:0] <= pins[1:0];
      else in_r[9:8] <= pins[9:8];

  always_latch
    if (!wr2_n && !xfer_n) dac_val <= in_r;
endmodule

/* verilog/dacldr_defines.vh */
`ifndef DACLDR_DEFINES_VH
`define DACLDR_DEFINES_VH

// Transfer modes.
`define DACLDR_MODE_AUTO   2'h0
`define DACLDR_MODE_PROC   2'h1
`define DACLDR_MODE_EXT    2'h2
`define DACLDR_MODE_FLOW   2'h3

// Bus arrangements.
`define DACLDR_BUS_8       2'h0
`define DACLDR_BUS_16      2'h1
`define DACLDR_BUS_ALONE   2'h2

// Word layout.
`define DACLDR_WORD_W      10
`define DACLDR_SRC_W       16
`define DACLDR_LJ_LSB      6

// Strobe timing at 25 MHz.
`define DACLDR_CLK_NS      40
`define DACLDR_SETUP_NS    80
`define DACLDR_PULSE_NS    200
`define DACLDR_HOLD_NS     80
`define DACLDR_SETUP_CYC   ((`DACLDR_SETUP_NS + `DACLDR_CLK_NS - 1) / `DACLDR_CLK_NS)
`define DACLDR_PULSE_CYC   ((`DACLDR_PULSE_NS + `DACLDR_CLK_NS - 1) / `DACLDR_CLK_NS)
`define DACLDR_HOLD_CYC    ((`DACLDR_HOLD_NS + `DACLDR_CLK_NS - 1) / `DACLDR_CLK_NS)
`define DACLDR_CNT_W       4

`endif

/* verilog/dacldr_host.v */
// Overview of operation
// RULE1 - Eight-bit bus needs two write cycles
// RULE2 - First write loads all, second two bits
// RULE3 - Right justified: low byte sent first
// RULE4 - Left justified: high byte sent first
// RULE5 - Justify pin high selects left justified
// RULE6 - Reduced variant: left only, high first
// RULE7 - Six surplus source bits are don't care
// RULE8 - Converter register load updates output
// RULE9 - Auto mode: second write also transfers
// RULE10 - Processor mode: third strobe with transfer
// RULE11 - Transfer from second select, byte from address
// RULE12 - External mode: outside logic times transfer
// RULE13 - Sixteen-bit bus: lines six-fifteen, byte high (code uses lines zero-nine when right justified)
// RULE14 - Sixteen-bit bus: flow, single, double buffered
// RULE15 - Stand-alone: single and double buffered
// RULE16 - Flow-through: all strobes held active
// RULE17 - Address bit zero drives byte and transfer
// RULE18 - Converter follows while transfer strobe low
// RULE19 - Input latch transparent while select, write low
// RULE20 - Byte select high loads all ten bits
`timescale 1ns/1ps
`include "dacldr_defines.vh"

module dacldr_host
(
  input  wire         CORE_CLK,
  input  wire         SRST,
  input  wire         START,
  input  wire [15:0]  SRC_WORD,
  input  wire [1:0]   BUS_MODE,
  input  wire [1:0]   XFER_MODE,
  input  wire         LEFT_JUSTIFY,
  input  wire         DOUBLE_BUF,
  input  wire         REDUCED_PART,
  input  wire         EXT_XFER_REQ,
  output reg          BUSY,
  output reg          DONE,
  output reg  [15:0]  DATA_BUS,
  output reg          CHIP_SELECT_N,
  output reg          WRITE_STROBE_FIRST_N,
  output reg          WRITE_STROBE_SECOND_N,
  output reg          BYTE_SELECT,
  output reg          XFER_N,
  output reg          JUSTIFY_SELECT,
  output reg          ADDR_BIT_ZERO
);

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_PULSE = 3'h2;
  localparam [2:0] ST_HOLD  = 3'h3;
  localparam [2:0] ST_NEXT  = 3'h4;
  localparam [2:0] ST_EXTW  = 3'h5;
  localparam [2:0] ST_FLOW  = 3'h6;

  localparam integer SETUP_C = `DACLDR_SETUP_CYC;
  localparam integer PULSE_C = `DACLDR_PULSE_CYC;
  localparam integer HOLD_C  = `DACLDR_HOLD_CYC;

  // ----------------------------------------------------------------
  // Input synchroniser for the external transfer request
  // ----------------------------------------------------------------
  reg ext_meta_r;
  reg ext_sync_r;

  always @(posedge CORE_CLK)
  begin
    ext_meta_r <= EXT_XFER_REQ;
    ext_sync_r <= ext_meta_r;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  reg  [2:0]               state_r;
  reg  [1:0]               step_r;
  reg  [1:0]               last_r;
  reg  [1:0]               xmode_r;
  reg  [1:0]               bmode_r;
  reg                      lj_r;
  reg  [9:0]               word_r;
  reg                      tload;
  reg  [`DACLDR_CNT_W-1:0] tcount;
  wire                     tdone;

  dacldr_timer u_timer
  (
    .clk    (CORE_CLK),
    .srst   (SRST),
    .load   (tload),
    .count  (tcount),
    .done_r (tdone)
  );

  // The effective justification is forced left on the reduced part.
  wire lj_eff = LEFT_JUSTIFY | REDUCED_PART;                  // [RULE5] [RULE6]

  // Bits 9:8 go out on the high byte, bits 7:0 on the low byte when
  // right justified; left justified keeps the word in bits 15:6.
  wire [7:0] rj_lo = word_r[7:0];
  wire [7:0] rj_hi = {6'h00, word_r[9:8]};
  wire [7:0] lj_hi = word_r[9:2];
  wire [7:0] lj_lo = {word_r[1:0], 6'h00};
  // Byte for 8-bit step 0 (first) or any later step (second).
  wire [7:0] byte_out = (step_r == 2'h0) ? (lj_r ? lj_hi : rj_lo) // [RULE3]
                                         : (lj_r ? lj_lo : rj_hi); // [RULE4]

  // Strobe pattern for the current step while pulsing.
  reg       wr2_act;
  reg       bsel;
  reg       xfer_act;
  always @*
  begin
    wr2_act  = 1'b0;
    bsel     = 1'b1;
    xfer_act = 1'b0;
    if (bmode_r == `DACLDR_BUS_8)
    begin
      // Only the first byte opens the whole latch. The transfer write
      // repeats the second byte, so its two-bit reload changes nothing.
      bsel     = (step_r == 2'h0); // [RULE2] [RULE20]
      wr2_act  = (step_r == 2'h2) || // [RULE10] [RULE11]
                 (step_r == 2'h1 && xmode_r == `DACLDR_MODE_AUTO); // [RULE9]
      xfer_act = wr2_act; // [RULE17]
    end
    else if (step_r == 2'h0)
    begin
      // Single buffered: both latches strobed together.
      wr2_act  = ~DOUBLE_BUF;                                 // [RULE14] [RULE15]
      xfer_act = ~DOUBLE_BUF;
    end
    else
    begin
      wr2_act  = 1'b1;                                        // [RULE8] [RULE18]
      xfer_act = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      state_r               <= ST_IDLE;
      tload                 <= 1'b0;
      BUSY                  <= 1'b0;
      DONE                  <= 1'b0;
      DATA_BUS              <= 16'h0000;
      CHIP_SELECT_N         <= 1'b1;
      WRITE_STROBE_FIRST_N  <= 1'b1;
      WRITE_STROBE_SECOND_N <= 1'b1;
      BYTE_SELECT           <= 1'b1;
      XFER_N                <= 1'b1;
      JUSTIFY_SELECT        <= 1'b0;
      ADDR_BIT_ZERO         <= 1'b1;
    end
    else
    begin
      tload <= 1'b0;
      DONE  <= 1'b0;
      JUSTIFY_SELECT <= lj_eff;                               // [RULE5]
      case (state_r)
        ST_IDLE:
        begin
          if (START)
          begin
            lj_r    <= lj_eff;
            xmode_r <= XFER_MODE;
            bmode_r <= BUS_MODE;
            step_r  <= 2'h0;
            // Ten bits only; the six surplus source bits are dropped.
            word_r  <= lj_eff ? SRC_WORD[15:`DACLDR_LJ_LSB]
                              : SRC_WORD[9:0];                // [RULE7]
            if (BUS_MODE != `DACLDR_BUS_8)
              last_r <= DOUBLE_BUF ? 2'h1 : 2'h0;
            else if (XFER_MODE == `DACLDR_MODE_PROC)
              last_r <= 2'h2;                                 // [RULE10]
            else
              last_r <= 2'h1;                                 // [RULE1]
            BUSY   <= 1'b1;
            if (BUS_MODE != `DACLDR_BUS_8
                && XFER_MODE == `DACLDR_MODE_FLOW)
              state_r <= ST_FLOW;
            else
            begin
              tcount  <= SETUP_C[`DACLDR_CNT_W-1:0];
              tload   <= 1'b1;
              state_r <= ST_SETUP;
            end
          end
        end
        ST_SETUP:
        begin
          CHIP_SELECT_N <= 1'b0;
          if (bmode_r == `DACLDR_BUS_8)
            DATA_BUS <= {byte_out, byte_out};
          else
            DATA_BUS <= lj_r ? {word_r, 6'h00}
                             : {6'h00, word_r};               // [RULE13]
          BYTE_SELECT   <= bsel;
          ADDR_BIT_ZERO <= bsel;                              // [RULE17]
          if (!tload && tdone)
          begin
            tcount  <= PULSE_C[`DACLDR_CNT_W-1:0];
            tload   <= 1'b1;
            state_r <= ST_PULSE;
          end
        end
        ST_PULSE:
        begin
          WRITE_STROBE_FIRST_N  <= 1'b0;                      // [RULE19]
          WRITE_STROBE_SECOND_N <= ~wr2_act;
          XFER_N                <= ~xfer_act;
          if (!tload && tdone)
          begin
            tcount  <= HOLD_C[`DACLDR_CNT_W-1:0];
            tload   <= 1'b1;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          WRITE_STROBE_FIRST_N  <= 1'b1;
          WRITE_STROBE_SECOND_N <= 1'b1;
          XFER_N                <= 1'b1;
          if (!tload && tdone)
          begin
            CHIP_SELECT_N <= 1'b1;
            state_r       <= ST_NEXT;
          end
        end
        ST_NEXT:
        begin
          if (step_r == last_r)
          begin
            if (bmode_r == `DACLDR_BUS_8
                && xmode_r == `DACLDR_MODE_EXT)
              state_r <= ST_EXTW;                             // [RULE12]
            else
            begin
              BUSY    <= 1'b0;
              DONE    <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
          else
          begin
            step_r  <= step_r + 2'h1;
            tcount  <= SETUP_C[`DACLDR_CNT_W-1:0];
            tload   <= 1'b1;
            state_r <= ST_SETUP;
          end
        end
        ST_EXTW:
        begin
          // External logic owns the transfer strobe; wait for its request.
          if (ext_sync_r)
          begin
            BUSY    <= 1'b0;
            DONE    <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_FLOW:
        begin
          CHIP_SELECT_N         <= 1'b0;                      // [RULE16]
          WRITE_STROBE_FIRST_N  <= 1'b0;
          WRITE_STROBE_SECOND_N <= 1'b0;
          XFER_N                <= 1'b0;
          BYTE_SELECT           <= 1'b1;
          ADDR_BIT_ZERO         <= 1'b1; // [RULE17]
          DATA_BUS <= lj_r ? {SRC_WORD[15:6], 6'h00}
                           : {6'h00, SRC_WORD[9:0]};
          if (!START)
          begin
            CHIP_SELECT_N         <= 1'b1;
            WRITE_STROBE_FIRST_N  <= 1'b1;
            WRITE_STROBE_SECOND_N <= 1'b1;
            XFER_N                <= 1'b1;
            BUSY                  <= 1'b0;
            DONE                  <= 1'b1;
            state_r               <= ST_IDLE;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

/* verilog/dacldr_timer.v */
`timescale 1ns/1ps
`include "dacldr_defines.vh"

module dacldr_timer
(
  input  wire                      clk,
  input  wire                      srst,
  input  wire                      load,
  input  wire [`DACLDR_CNT_W-1:0]  count,
  output reg                       done_r
);

  reg [`DACLDR_CNT_W-1:0] cnt_r;

  // Loaded with a count, done rises once that many edges have passed.
  always @(posedge clk)
  begin
    if (srst)
    begin
      cnt_r  <= {`DACLDR_CNT_W{1'b0}};
      done_r <= 1'b1;
    end
    else if (load)
    begin
      cnt_r  <= count;
      done_r <= 1'b0;
    end
    else if (cnt_r > {{(`DACLDR_CNT_W-1){1'b0}}, 1'b1})
    begin
      cnt_r  <= cnt_r - {{(`DACLDR_CNT_W-1){1'b0}}, 1'b1};
    end
    else
    begin
      cnt_r  <= {`DACLDR_CNT_W{1'b0}};
      done_r <= 1'b1;
    end
  end

endmodule
